// file: rtl/bhs_regs.sv
// Primary status, revision/class, cache line size and primary latency timer registers
//
// Notes on behaviour
// [RULE1] Bit 31 sets on parity error, write-one clears
// [RULE2] Bit 30 sets when system error driven
// [RULE3] Bit 29 sets on received master abort
// [RULE4] Bit 28 sets on received target abort
// [RULE5] Bit 27 sets on signalled target abort
// [RULE6] Bits 26:25 read fixed 01, medium decode
// [RULE7] Bit 24 sets on data parity error
// [RULE8] Bit 23 reads 0 PCI-X, 1 conventional
// [RULE9] Bit 21 always reads 1, 66MHz capable
// [RULE10] Bit 20 reads 0, no capability list
// [RULE11] Bits 22 and 19:16 read zero
// [RULE12] Revision byte read-only at 08h bits 7:0
// [RULE13] Base class 06h in bits 31:24
// [RULE14] Sub-class 04h in bits 23:16
// [RULE15] Programming interface reads zero
// [RULE16] Writable cache line size, conventional mode only; writes are stored in PCI-X mode too, only cache_line_valid is gated
// [RULE17] One-hot decode: 32, 16, 8, 4 doublewords
// [RULE18] Software writes zero to bits 7:6, 1:0
// [RULE19] Latency timer bits 15:11 writable
// [RULE20] Latency timer bits 10:8 hardwired zero
// [RULE21] Write-one-clear bits read current state
// [RULE22] Zero writes keep; read-only writes discarded
//
// Implementation choice: the plain strobed port.
module bhs_regs
  import bhs_pkg::*;
#(
  parameter logic [7:0] REVISION = BHS_REVISION_DEFAULT
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire bhs_bus_req_t bus_req,
  input  wire bhs_events_t  events,
  input  wire logic         pcix_mode,
  output logic [31:0]       rdata,
  output logic [5:0]        cache_line_dwords,
  output logic              cache_line_valid,
  output logic [7:0]        latency_timer
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0] rdata_q;
  logic        st_parity_det;
  logic        st_sig_serr;
  logic        st_rcv_mabort;
  logic        st_rcv_tabort;
  logic        st_sig_tabort;
  logic        st_data_parity;
  logic [7:0]  cls;
  logic [4:0]  lat_hi;
  logic [5:0]  cls_dw_q;
  logic        cls_valid_q;

  // ****************************************
  // Decode
  // ****************************************
  // A strobe picks one word; the bus never raises write and read together
  function automatic logic addr_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] offset);
    addr_hit = strobe && (addr == offset);
  endfunction

  wire logic        wr_status = addr_hit(bus_req.wr, bus_req.addr, BHS_OFF_CMD_STATUS);
  wire logic        wr_cls    = addr_hit(bus_req.wr, bus_req.addr, BHS_OFF_CLS_LAT);
  wire logic        rd_status = addr_hit(bus_req.rd, bus_req.addr, BHS_OFF_CMD_STATUS);
  wire logic        rd_class  = addr_hit(bus_req.rd, bus_req.addr, BHS_OFF_REV_CLASS);
  wire logic        rd_cls    = addr_hit(bus_req.rd, bus_req.addr, BHS_OFF_CLS_LAT);
  wire logic [31:0] wd        = bus_req.wdata;

  // Write-one-clear: a pending event wins over a clear in the same cycle
  function automatic logic w1c_next(input logic cur, input logic set, input logic clr);
    w1c_next = set | (cur & ~clr);
  endfunction

  // ****************************************
  // Flag: address or data parity error seen
  // ****************************************
  // Raised by the primary-side parity checker
  // A level on the event input keeps the flag set for as long as it stands
  wire logic set_parity_det  = events.parity_det;
  wire logic clr_parity_det  = wr_status & wd[BHS_ST_PARITY_DET];
  wire logic next_parity_det = w1c_next(st_parity_det, set_parity_det,
                                        clr_parity_det);          // [RULE1] [RULE21] [RULE22]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_parity_det <= 1'b0;
    end else begin
      st_parity_det <= next_parity_det;
    end
  end

  // ****************************************
  // Flag: system error driven
  // ****************************************
  // Raised when the primary side drives its system error line
  // Only a written one clears it, so software cannot lose a new report
  wire logic set_sig_serr  = events.sig_serr;
  wire logic clr_sig_serr  = wr_status & wd[BHS_ST_SIG_SERR];
  wire logic next_sig_serr = w1c_next(st_sig_serr, set_sig_serr,
                                      clr_sig_serr);              // [RULE2]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_sig_serr <= 1'b0;
    end else begin
      st_sig_serr <= next_sig_serr;
    end
  end

  // ****************************************
  // Flag: own transaction ended by master abort
  // ****************************************
  // Raised by the primary-side master when no target claimed its cycle
  // Same set and clear timing as every other flag
  wire logic set_rcv_mabort  = events.rcv_mabort;
  wire logic clr_rcv_mabort  = wr_status & wd[BHS_ST_RCV_MABORT];
  wire logic next_rcv_mabort = w1c_next(st_rcv_mabort, set_rcv_mabort,
                                        clr_rcv_mabort);          // [RULE3]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_rcv_mabort <= 1'b0;
    end else begin
      st_rcv_mabort <= next_rcv_mabort;
    end
  end

  // ****************************************
  // Flag: own transaction ended by target abort
  // ****************************************
  // Raised by the primary-side master when the target aborted its cycle
  // Same set and clear timing as every other flag
  wire logic set_rcv_tabort  = events.rcv_tabort;
  wire logic clr_rcv_tabort  = wr_status & wd[BHS_ST_RCV_TABORT];
  wire logic next_rcv_tabort = w1c_next(st_rcv_tabort, set_rcv_tabort,
                                        clr_rcv_tabort);          // [RULE4]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_rcv_tabort <= 1'b0;
    end else begin
      st_rcv_tabort <= next_rcv_tabort;
    end
  end

  // ****************************************
  // Flag: target abort signalled as target
  // ****************************************
  // Raised by the primary-side target when it aborts a cycle itself
  // Cleared on reset like its neighbours, for a uniform view after reset
  wire logic set_sig_tabort  = events.sig_tabort;
  wire logic clr_sig_tabort  = wr_status & wd[BHS_ST_SIG_TABORT];
  wire logic next_sig_tabort = w1c_next(st_sig_tabort, set_sig_tabort,
                                        clr_sig_tabort);          // [RULE5]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_sig_tabort <= 1'b0;
    end else begin
      st_sig_tabort <= next_sig_tabort;
    end
  end

  // ****************************************
  // Flag: data parity error seen
  // ****************************************
  // Raised by the primary-side data phase checker
  // Same set and clear timing as every other flag
  wire logic set_data_parity  = events.data_parity;
  wire logic clr_data_parity  = wr_status & wd[BHS_ST_DATA_PARITY];
  wire logic next_data_parity = w1c_next(st_data_parity, set_data_parity,
                                         clr_data_parity);        // [RULE7]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_data_parity <= 1'b0;
    end else begin
      st_data_parity <= next_data_parity;
    end
  end

  // ****************************************
  // Cache line size
  // ****************************************
  // One-hot size decode; illegal or zero patterns give no usable line size
  function automatic logic [5:0] cls_decode(input logic [7:0] v);
    unique case (v)
      8'h20:   cls_decode = BHS_DW_32;
      8'h10:   cls_decode = BHS_DW_16;
      8'h08:   cls_decode = BHS_DW_8;
      8'h04:   cls_decode = BHS_DW_4;
      default: cls_decode = BHS_DW_NONE;
    endcase
  endfunction

  // Unsupported bits are stored as written; software is expected to keep them zero
  wire logic [7:0] next_cls    = wr_cls ? wd[7:0] : cls;        // [RULE16] [RULE18]
  wire logic [5:0] next_cls_dw = cls_decode(next_cls);          // [RULE17]
  // Line size only steers bursts and prefetch in conventional mode
  wire logic next_cls_valid = (next_cls_dw != BHS_DW_NONE) && !pcix_mode; // [RULE16]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cls <= BHS_CLS_RESET;
    end else begin
      cls <= next_cls;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cls_dw_q <= BHS_DW_NONE;
    end else begin
      cls_dw_q <= next_cls_dw;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cls_valid_q <= 1'b0;
    end else begin
      cls_valid_q <= next_cls_valid;
    end
  end

  // ****************************************
  // Primary latency timer
  // ****************************************
  // Low three bits never store anything, so the timer moves in steps of eight
  logic [7:0]      lat_q;
  wire logic [4:0] next_lat_hi = wr_cls ? wd[15:11] : lat_hi;          // [RULE19]
  wire logic [7:0] next_lat    = {next_lat_hi, BHS_LAT_LOW_FIXED};     // [RULE20]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lat_hi <= BHS_LAT_RESET;
    end else begin
      lat_hi <= next_lat_hi;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lat_q <= {BHS_LAT_RESET, BHS_LAT_LOW_FIXED};
    end else begin
      lat_q <= next_lat;
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  // The low half belongs to the command register, which lives elsewhere
  wire logic [15:0] st_cmd_half  = 16'h0000;
  wire logic [1:0]  st_devsel    = BHS_DEVSEL_MEDIUM;    // [RULE6]
  wire logic        st_fast_b2b  = ~pcix_mode;           // [RULE8]
  wire logic        st_cap_66mhz = BHS_CAP_66MHZ_VAL;    // [RULE9]
  wire logic        st_cap_list  = BHS_CAP_LIST_VAL;     // [RULE10]

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;                             // [RULE11]
    status_word[15:0]               = st_cmd_half;
    status_word[BHS_ST_PARITY_DET]  = st_parity_det;         // [RULE21]
    status_word[BHS_ST_SIG_SERR]    = st_sig_serr;
    status_word[BHS_ST_RCV_MABORT]  = st_rcv_mabort;
    status_word[BHS_ST_RCV_TABORT]  = st_rcv_tabort;
    status_word[BHS_ST_SIG_TABORT]  = st_sig_tabort;
    status_word[BHS_ST_DATA_PARITY] = st_data_parity;
    status_word[26:25]              = st_devsel;
    status_word[BHS_ST_FAST_B2B]    = st_fast_b2b;
    status_word[BHS_ST_CAP_66MHZ]   = st_cap_66mhz;
    status_word[BHS_ST_CAP_LIST]    = st_cap_list;
  end

  // ****************************************
  // Revision and class code word
  // ****************************************
  // Read-only words have no storage, so writes to them do nothing
  wire logic [7:0]  rev_field  = REVISION;           // [RULE12]
  wire logic [7:0]  prog_if    = BHS_PROG_IF;        // [RULE15]
  wire logic [7:0]  sub_class  = BHS_SUB_CLASS;      // [RULE14]
  wire logic [7:0]  base_class = BHS_BASE_CLASS;     // [RULE13]
  wire logic [31:0] class_word = {base_class, sub_class, prog_if, rev_field}; // [RULE22]

  // ****************************************
  // Line size and latency word
  // ****************************************
  // The upper half holds header type and self-test, which live elsewhere
  wire logic [15:0] cls_word_hi = 16'h0000;
  wire logic [31:0] cls_word    = {cls_word_hi, lat_hi, BHS_LAT_LOW_FIXED, cls}; // [RULE20]

  // ****************************************
  // Read mux
  // ****************************************
  // Read data is zero outside the cycle after a read and for unmapped words
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (1'b1)
      rd_status: next_rdata = status_word;
      rd_class:  next_rdata = class_word;
      rd_cls:    next_rdata = cls_word;
      default:   next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= next_rdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a register, so nothing combinational leaves the block
  assign rdata             = rdata_q;
  assign cache_line_dwords = cls_dw_q;
  assign cache_line_valid  = cls_valid_q;
  assign latency_timer     = lat_q;

endmodule

// file: rtl/bhs_pkg.sv
// Package: offsets, field layout and constants for the bridge header status/class registers
package bhs_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] BHS_OFF_CMD_STATUS = 8'h04;
  localparam logic [7:0] BHS_OFF_REV_CLASS  = 8'h08;
  localparam logic [7:0] BHS_OFF_CLS_LAT    = 8'h0C;

  // ****************************************
  // Primary status field positions (word bits)
  // ****************************************
  localparam int BHS_ST_PARITY_DET  = 31;
  localparam int BHS_ST_SIG_SERR    = 30;
  localparam int BHS_ST_RCV_MABORT  = 29;
  localparam int BHS_ST_RCV_TABORT  = 28;
  localparam int BHS_ST_SIG_TABORT  = 27;
  localparam int BHS_ST_DATA_PARITY = 24;
  localparam int BHS_ST_FAST_B2B    = 23;
  localparam int BHS_ST_CAP_66MHZ   = 21;
  localparam int BHS_ST_CAP_LIST    = 20;

  localparam logic [1:0] BHS_DEVSEL_MEDIUM = 2'h1;
  localparam logic       BHS_CAP_66MHZ_VAL = 1'b1;
  localparam logic       BHS_CAP_LIST_VAL  = 1'b0;

  // ****************************************
  // Class code and revision
  // ****************************************
  localparam logic [7:0] BHS_BASE_CLASS = 8'h06;
  localparam logic [7:0] BHS_SUB_CLASS  = 8'h04;
  localparam logic [7:0] BHS_PROG_IF    = 8'h00;
  // Arbitrary neutral revision value
  localparam logic [7:0] BHS_REVISION_DEFAULT = 8'h01;

  // ****************************************
  // Cache line size / latency timer
  // ****************************************
  localparam logic [7:0] BHS_CLS_RESET     = 8'h00;
  localparam logic [4:0] BHS_LAT_RESET     = 5'h00;
  localparam logic [2:0] BHS_LAT_LOW_FIXED = 3'h0;
  localparam int         BHS_CLS_BIT_32DW  = 5;
  localparam int         BHS_CLS_BIT_16DW  = 4;
  localparam int         BHS_CLS_BIT_8DW   = 3;
  localparam int         BHS_CLS_BIT_4DW   = 2;
  localparam logic [5:0] BHS_DW_32 = 6'h20;
  localparam logic [5:0] BHS_DW_16 = 6'h10;
  localparam logic [5:0] BHS_DW_8  = 6'h08;
  localparam logic [5:0] BHS_DW_4  = 6'h04;
  localparam logic [5:0] BHS_DW_NONE = 6'h00;

  // Error events from primary-side transaction logic, one-cycle pulses
  typedef struct packed {
    logic parity_det;
    logic sig_serr;
    logic rcv_mabort;
    logic rcv_tabort;
    logic sig_tabort;
    logic data_parity;
  } bhs_events_t;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bhs_bus_req_t;

endpackage

// file: dv/bhs_regs_chk.sv
// Port-level assertions for the bridge header status and class registers
module bhs_regs_chk
  import bhs_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         rst,
  input wire bhs_bus_req_t bus_req,
  input wire bhs_events_t  events,
  input wire logic         pcix_mode,
  input wire logic [31:0]  rdata,
  input wire logic [5:0]   cache_line_dwords,
  input wire logic         cache_line_valid,
  input wire logic [7:0]   latency_timer
);
  // ****************************************
  // Decodes and properties
  // ****************************************
  wire logic       rd4 = bus_req.rd && bus_req.addr == BHS_OFF_CMD_STATUS;
  wire logic       rd8 = bus_req.rd && bus_req.addr == BHS_OFF_REV_CLASS;
  wire logic       wr4 = bus_req.wr && bus_req.addr == BHS_OFF_CMD_STATUS;
  wire logic       wrc = bus_req.wr && bus_req.addr == BHS_OFF_CLS_LAT;
  wire logic [4:0] lat_w = bus_req.wdata[15:11];
  wire logic [7:0] cls_w = bus_req.wdata[7:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_DEVSEL: assert property (rd4 |=> rdata[26:25] == BHS_DEVSEL_MEDIUM)
    else $error("devsel timing field wrong");
  AST_FB2B: assert property (rd4 |=> rdata[23] == !$past(pcix_mode))
    else $error("back-to-back capable bit does not follow mode");
  AST_CAP66: assert property (rd4 |=> rdata[21] && !rdata[20])
    else $error("66 MHz or capability bit wrong");
  AST_RSVD: assert property (rd4 |=> rdata[22] == 1'b0 && rdata[19:16] == 4'h0)
    else $error("reserved status bits not zero");
  AST_CLASS: assert property (rd8 |=> rdata[31:8] == 24'h060400)
    else $error("class code word wrong");
  AST_SERR: assert property (events.sig_serr ##1 rd4 |=> rdata[30])
    else $error("system error flag not set");
  AST_W1C: assert property ((wr4 && bus_req.wdata[31] && !events.parity_det) ##1
    (rd4 && !events.parity_det) |=> !rdata[31])
    else $error("parity flag not cleared by write of one");
  AST_LAT: assert property (wrc |=> latency_timer == {$past(lat_w), 3'h0})
    else $error("latency timer value wrong after write");
  AST_CLS: assert property ((wrc && cls_w == 8'h10 && !pcix_mode) ##1 (!pcix_mode && !wrc)
    |=> cache_line_dwords == BHS_DW_16 && cache_line_valid)
    else $error("cache line decode wrong");
endmodule

bind bhs_regs bhs_regs_chk bhs_regs_chk_inst (.core_clk(core_clk), .rst(rst),
  .bus_req(bus_req), .events(events), .pcix_mode(pcix_mode), .rdata(rdata),
  .cache_line_dwords(cache_line_dwords), .cache_line_valid(cache_line_valid),
  .latency_timer(latency_timer));

// file: dv/bhs_regs_test.sv
// Self-checking bench for the bridge header status and class registers
module bhs_regs_test
  import bhs_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Stimulus, tasks and scenarios
  // ****************************************
  // Fixed status bits 25, 23 and 21 in conventional mode
  localparam logic [31:0] ST_BASE = 32'h02A00000;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  bhs_bus_req_t bus_req = '0;
  bhs_events_t  events = '0;
  logic         pcix_mode = 1'b0;
  logic [31:0]  rdata;
  logic [5:0]   cache_line_dwords;
  logic         cache_line_valid;
  logic [7:0]   latency_timer;
  int           fail_count = 0;
  int           checks = 0;
  always #2 core_clk = ~core_clk;
  bhs_regs #(.REVISION(8'h5A)) bhs_regs_inst (.core_clk(core_clk), .rst(rst),
    .bus_req(bus_req), .events(events), .pcix_mode(pcix_mode), .rdata(rdata),
    .cache_line_dwords(cache_line_dwords), .cache_line_valid(cache_line_valid),
    .latency_timer(latency_timer));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write leaves the strobe up; every write here is followed by a read at once
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk) bus_req <= '0;
    #1 chk(rdata, e);
  endtask
  task automatic t_cls();
    logic [7:0] cls[5] = '{8'h30, 8'h20, 8'h10, 8'h08, 8'h04};
    for (int i = 0; i < 5; i++) begin
      wr_reg(BHS_OFF_CLS_LAT, {24'hFFFFFF, cls[i]});
      rd_chk(BHS_OFF_CLS_LAT, {16'h0, 8'hF8, cls[i]});
      @(posedge core_clk);
      #1 chk(32'(cache_line_dwords), i > 0 ? 32'(cls[i]) : 32'h0);
      chk(32'(cache_line_valid), i > 0 ? 32'h1 : 32'h0);
      chk(32'(latency_timer), 32'hF8);
    end
  endtask
  task automatic t_fixed();
    rd_chk(BHS_OFF_CMD_STATUS, ST_BASE);
    wr_reg(BHS_OFF_REV_CLASS, 32'hFFFFFFFF);
    rd_chk(BHS_OFF_REV_CLASS, 32'h0604005A);
    wr_reg(8'h10, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'h0);
    @(posedge core_clk) pcix_mode <= 1'b1;
    rd_chk(BHS_OFF_CMD_STATUS, ST_BASE & ~32'h00800000);
    @(posedge core_clk) pcix_mode <= 1'b0;
    #1 chk(32'(cache_line_valid), 32'h0);
  endtask
  task automatic t_events();
    int pos[6] = '{24, 27, 28, 29, 30, 31};
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk) events <= 6'(1 << i);
      rd_chk(BHS_OFF_CMD_STATUS, ST_BASE | (32'h1 << pos[i]));
      @(posedge core_clk) events <= '0;
      wr_reg(BHS_OFF_CMD_STATUS, 32'h0);
      rd_chk(BHS_OFF_CMD_STATUS, ST_BASE | (32'h1 << pos[i]));
      wr_reg(BHS_OFF_CMD_STATUS, 32'hFFFFFFFF);
      rd_chk(BHS_OFF_CMD_STATUS, ST_BASE);
      // Event and clear in one cycle: the event must win
      @(posedge core_clk) events <= 6'(1 << i);
      wr_reg(BHS_OFF_CMD_STATUS, 32'hFFFFFFFF);
      rd_chk(BHS_OFF_CMD_STATUS, ST_BASE | (32'h1 << pos[i]));
      @(posedge core_clk) events <= '0;
      wr_reg(BHS_OFF_CMD_STATUS, 32'hFFFFFFFF);
      rd_chk(BHS_OFF_CMD_STATUS, ST_BASE);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_cls();
    t_fixed();
    t_events();
    complete_run();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    complete_run();
  end
endmodule
